// ### logic/standby_control.sv
// Purpose: Standby entry and release control for a 4-bit core
// Assumes: STBY_EXEC is a one-cycle pulse from the instruction sequencer
// Notes:   Clock keeps running here; OSC_STOP tells the clock gate to stop
//
// Operation
// R1: Sleep entered only by standby instruction, and only with wake flag clear.
// R2: Leaving any sleep, by supply reset or wake condition, sets wake flag.
// R3: Standby with flag set: no sleep; flag takes the wake condition value.
// R4: Wake condition already true at execution: skip sleep, set wake flag.
// R5: Reset wake resumes at address 0; condition wake resumes after instruction.
// R6: Codes 000/011: deep sleep, all key I/O high, any key input wakes.
// R7: Code 110: deep sleep, only key I/O zero high, key input wakes.
// R8: Operand bit 3 adds qualified sense pins as deep-sleep wake sources.
// R9: Sense 0/1 need input mode bits 0/2; sense 2 needs bit 3.
// R10: Code 101: light sleep, no precondition, wakes when timer reaches zero.
// R11: Undefined operand or unmet precondition triggers an internal reset.
// R12: Deep sleep deferred until timer count and output enable are zero.
// R13: Deep wake runs oscillator wait; returns to deep if condition gone.
// R14: Program puts an idle instruction first after a deep-sleep wake.
// R15: Deep sleep stops the oscillator; light sleep halts only execution.
// R16: Oscillator wait is a cycle counter of parameterised length.

`timescale 1ns/1ps
`default_nettype none

module standby_control #(
  parameter int unsigned OSC_WAIT_LEN = standby_pkg::OSC_WAIT_CYCLES
) (
  input  wire logic                              CLK,
  input  wire logic                              RST_N,
  input  wire logic                              AWVALID,
  output var  logic                              AWREADY,
  input  wire logic [standby_pkg::ADDR_W-1:0]    AWADDR,
  input  wire logic [2:0]                        AWPROT,
  input  wire logic                              WVALID,
  output var  logic                              WREADY,
  input  wire logic [31:0]                       WDATA,
  input  wire logic [3:0]                        WSTRB,
  output var  logic                              BVALID,
  input  wire logic                              BREADY,
  output var  logic [1:0]                        BRESP,
  input  wire logic                              ARVALID,
  output var  logic                              ARREADY,
  input  wire logic [standby_pkg::ADDR_W-1:0]    ARADDR,
  input  wire logic [2:0]                        ARPROT,
  output var  logic                              RVALID,
  input  wire logic                              RREADY,
  output var  logic [31:0]                       RDATA,
  output var  logic [1:0]                        RRESP,
  input  wire logic                              STBY_EXEC,
  input  wire logic [3:0]                        STBY_OPERAND,
  input  wire logic                              FLAG_WR,
  input  wire logic                              FLAG_WR_VAL,
  input  wire logic [standby_pkg::KEY_IO_W-1:0]  KEY_IO_PINS_HIGH,
  input  wire logic [standby_pkg::KEY_IN_W-1:0]  KEY_INPUT_PINS,
  input  wire logic [standby_pkg::SENSE_W-1:0]   SENSE_PINS,
  input  wire logic [standby_pkg::PCR_W-1:0]     PIN_CONTROL_REG,
  input  wire logic [standby_pkg::TIMER_W-1:0]   TIMER_COUNT,
  input  wire logic                              TIMER_OUTPUT_ENABLE,
  input  wire logic                              SUPPLY_MONITOR_RESET,
  output var  logic                              WAKE_FLAG,
  output var  logic                              CORE_HALT,
  output var  logic                              OSC_STOP,
  output var  logic                              INTERNAL_RESET,
  output var  logic                              RESUME_VALID,
  output var  logic                              RESUME_AT_ZERO
);
  import standby_pkg::*;

  // Refuse a wait the counter cannot hold
  if (OSC_WAIT_LEN < 1 || OSC_WAIT_LEN > 65535) begin : g_bad_wait
    $error("OSC_WAIT_LEN out of range");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Key input, sense and supply pins are asynchronous; only the second stage is read
  logic [KEY_IN_W-1:0] key_meta_r, key_s_r;
  logic [SENSE_W-1:0]  sns_meta_r, sns_s_r;
  logic                sup_meta_r, sup_s_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      key_meta_r <= '0;
      key_s_r    <= '0;
      sns_meta_r <= '0;
      sns_s_r    <= '0;
      sup_meta_r <= 1'b0;
      sup_s_r    <= 1'b0;
    end else begin
      key_meta_r <= KEY_INPUT_PINS;
      key_s_r    <= key_meta_r;
      sns_meta_r <= SENSE_PINS;
      sns_s_r    <= sns_meta_r;
      sup_meta_r <= SUPPLY_MONITOR_RESET;
      sup_s_r    <= sup_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Operand decode and wake conditions
  // ----------------------------------------------------------------------
  sleep_state_e state_r, state_nxt;
  logic [3:0]   op_r, op_nxt;
  logic [3:0]   cur_op;
  logic [2:0]   low;
  logic         is_deep, is_light, precond_ok, legal;
  logic         sense_qual, deep_wake, timer_zero, timer_busy, wake_cond;
  logic [WAIT_W-1:0] wait_len_r;

  // In sleep the latched operand selects the wake sources
  assign cur_op     = (state_r == ST_RUN) ? STBY_OPERAND : op_r;
  assign low        = cur_op[2:0];
  assign is_deep    = (low == OP_DEEP_ALL_A) || (low == OP_DEEP_ALL_B) ||
                      (low == OP_DEEP_KEY0);
  assign is_light   = (low == OP_LIGHT); // R10
  assign legal      = is_deep || is_light;
  assign precond_ok = is_light ||
    (((low == OP_DEEP_ALL_A) || (low == OP_DEEP_ALL_B)) &&
     (&KEY_IO_PINS_HIGH)) || // R6
    ((low == OP_DEEP_KEY0) && (KEY_IO_PINS_HIGH == KEY_IO_ONLY_ZERO)); // R7
  // Sense pins wake only when configured for it
  assign sense_qual =
    (sns_s_r[0] && PIN_CONTROL_REG[PCR_S0_INPUT_BIT]) ||
    (sns_s_r[1] && PIN_CONTROL_REG[PCR_S1_INPUT_BIT]) ||
    (sns_s_r[2] && PIN_CONTROL_REG[PCR_S2_WAKE_BIT]); // R9
  assign deep_wake  = (|key_s_r) ||
                      (cur_op[OP_SENSE_BIT] && sense_qual); // R6 R7 R8
  assign timer_zero = (TIMER_COUNT == '0);
  assign timer_busy = !timer_zero || TIMER_OUTPUT_ENABLE; // R12
  assign wake_cond  = is_light ? timer_zero : deep_wake;

  // ----------------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------------
  osc_wait_if ow ();
  logic flag_r, flag_nxt, halt_nxt, osc_nxt, irst_nxt, res_nxt, zero_nxt;
  logic halt_r, osc_r, irst_r, res_r, zero_r;
  logic start_c;

  // Sequencer writes to the flag first so hardware sets override them
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    flag_nxt  = FLAG_WR ? FLAG_WR_VAL : flag_r;
    irst_nxt  = 1'b0;
    res_nxt   = 1'b0;
    zero_nxt  = zero_r;
    start_c   = 1'b0;
    unique case (state_r)
      ST_RUN: begin
        if (STBY_EXEC) begin
          if (!legal || !precond_ok) begin
            irst_nxt = 1'b1; // R11
          end else if (flag_r) begin
            flag_nxt = wake_cond; // R1 R3
            res_nxt  = 1'b1;
            zero_nxt = 1'b0;
          end else if (wake_cond) begin
            flag_nxt = 1'b1; // R4
            res_nxt  = 1'b1;
            zero_nxt = 1'b0;
          end else begin
            op_nxt = STBY_OPERAND;
            if (is_light) begin
              state_nxt = ST_LIGHT; // R10
            end else if (timer_busy) begin
              state_nxt = ST_DEFER; // R12
            end else begin
              state_nxt = ST_DEEP;
            end
          end
        end
      end
      ST_DEFER: begin
        if (!timer_busy) begin
          state_nxt = ST_DEEP; // R12
        end
      end
      ST_DEEP: begin
        if (wake_cond) begin
          state_nxt = ST_OSC_WAIT; // R13
          start_c   = 1'b1;
        end
      end
      ST_OSC_WAIT: begin
        if (ow.done) begin
          if (wake_cond) begin
            state_nxt = ST_RUN;
            flag_nxt  = 1'b1; // R2
            res_nxt   = 1'b1;
            zero_nxt  = 1'b0; // R5
          end else begin
            state_nxt = ST_DEEP; // R13
          end
        end
      end
      ST_LIGHT: begin
        if (wake_cond) begin
          state_nxt = ST_RUN;
          flag_nxt  = 1'b1; // R2
          res_nxt   = 1'b1;
          zero_nxt  = 1'b0; // R5
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    // Supply reset leaves any sleep and restarts at address zero
    if (sup_s_r && state_r != ST_RUN) begin
      state_nxt = ST_RUN;
      flag_nxt  = 1'b1; // R2
      res_nxt   = 1'b1;
      zero_nxt  = 1'b1; // R5
      start_c   = 1'b0;
    end
    halt_nxt = (state_nxt != ST_RUN); // R15
    osc_nxt  = (state_nxt == ST_DEEP); // R15
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
      op_r    <= '0;
      flag_r  <= 1'b0;
      halt_r  <= 1'b0;
      osc_r   <= 1'b0;
      irst_r  <= 1'b0;
      res_r   <= 1'b0;
      zero_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      flag_r  <= flag_nxt;
      halt_r  <= halt_nxt;
      osc_r   <= osc_nxt;
      irst_r  <= irst_nxt;
      res_r   <= res_nxt;
      zero_r  <= zero_nxt;
    end
  end

  assign ow.start = start_c;
  assign ow.len   = wait_len_r;

  osc_wait_counter u_wait (
    .clk   (CLK),
    .rst_n (RST_N),
    .w     (ow.counter)
  );

  assign WAKE_FLAG      = flag_r;
  assign CORE_HALT      = halt_r;
  assign OSC_STOP       = osc_r;
  assign INTERNAL_RESET = irst_r;
  assign RESUME_VALID   = res_r;
  assign RESUME_AT_ZERO = zero_r;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic              awh_r, awh_nxt, wh_r, wh_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0]       wd_r, wd_nxt, rd_nxt, rd_r, stat;
  logic [3:0]        ws_r, ws_nxt;
  logic [WAIT_W-1:0] wait_nxt;
  logic              awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
  logic              arr_r, arr_nxt, rv_r, rv_nxt;
  logic [1:0]        br_r, br_nxt, rr_r, rr_nxt;

  always_comb begin
    stat = '0;
    stat[STAT_STATE_LSB +: 5] = state_r;
    stat[STAT_FLAG_BIT]       = flag_r;
    stat[STAT_ZERO_BIT]       = zero_r;
  end

  // Address and data are taken in either order; one write at a time
  always_comb begin
    awh_nxt = awh_r;  awa_nxt = awa_r;
    wh_nxt  = wh_r;   wd_nxt  = wd_r;   ws_nxt = ws_r;
    bv_nxt  = bv_r;   br_nxt  = br_r;   wait_nxt = wait_len_r;
    rv_nxt  = rv_r;   rr_nxt  = rr_r;   rd_nxt = rd_r;
    arr_nxt = arr_r;
    if (AWVALID && awr_r) begin
      awh_nxt = 1'b1;
      awa_nxt = AWADDR;
    end
    if (WVALID && wr_r) begin
      wh_nxt = 1'b1;
      wd_nxt = WDATA;
      ws_nxt = WSTRB;
    end
    if (bv_r && BREADY) begin
      bv_nxt = 1'b0;
    end
    if (awh_r && wh_r && !bv_r) begin
      bv_nxt  = 1'b1;
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      br_nxt  = RESP_OKAY;
      if (awa_r == ADDR_WAIT_LEN) begin
        for (int i = 0; i < WAIT_W / 8; i++) begin
          if (ws_r[i]) begin
            wait_nxt[i*8 +: 8] = wd_r[i*8 +: 8];
          end
        end
      end else if (awa_r != ADDR_STATUS) begin
        br_nxt = RESP_SLVERR; // Unmapped address; status writes are ignored with OKAY
      end
    end
    awr_nxt = !awh_nxt;
    wr_nxt  = !wh_nxt;
    // Read answers one cycle after the address is taken
    if (ARVALID && arr_r) begin
      rv_nxt  = 1'b1;
      arr_nxt = 1'b0;
      rr_nxt  = RESP_OKAY;
      if (ARADDR == ADDR_STATUS) begin
        rd_nxt = stat;
      end else if (ARADDR == ADDR_WAIT_LEN) begin
        rd_nxt = {{(32-WAIT_W){1'b0}}, wait_len_r};
      end else begin
        rd_nxt = '0;
        rr_nxt = RESP_SLVERR;
      end
    end else if (rv_r && RREADY) begin
      rv_nxt  = 1'b0;
      arr_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      awh_r <= 1'b0;  awa_r <= '0;  wh_r <= 1'b0;  wd_r <= '0;
      ws_r  <= '0;    bv_r  <= 1'b0; br_r <= RESP_OKAY;
      awr_r <= 1'b1;  wr_r  <= 1'b1; arr_r <= 1'b1;
      rv_r  <= 1'b0;  rr_r  <= RESP_OKAY; rd_r <= '0;
      wait_len_r <= WAIT_W'(OSC_WAIT_LEN);
    end else begin
      awh_r <= awh_nxt; awa_r <= awa_nxt; wh_r <= wh_nxt; wd_r <= wd_nxt;
      ws_r  <= ws_nxt;  bv_r  <= bv_nxt;  br_r <= br_nxt;
      awr_r <= awr_nxt; wr_r  <= wr_nxt;  arr_r <= arr_nxt;
      rv_r  <= rv_nxt;  rr_r  <= rr_nxt;  rd_r <= rd_nxt;
      wait_len_r <= wait_nxt;
    end
  end

  assign AWREADY = awr_r;
  assign WREADY  = wr_r;
  assign BVALID  = bv_r;
  assign BRESP   = br_r;
  assign ARREADY = arr_r;
  assign RVALID  = rv_r;
  assign RDATA   = rd_r;
  assign RRESP   = rr_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic run_exec;
  assign run_exec = STBY_EXEC && state_r == ST_RUN && !sup_s_r;

  a_entry_flag_clear: assert property ( // R1
    state_r == ST_RUN && flag_r |=> state_r == ST_RUN)
    else $error("sleep entered with wake flag set");
  a_wake_sets_flag: assert property ( // R2
    RESUME_VALID && $past(state_r) != ST_RUN |-> WAKE_FLAG)
    else $error("sleep left without setting wake flag");
  a_busy_flag_follow: assert property ( // R3
    run_exec && legal && precond_ok && flag_r && !FLAG_WR
    |=> WAKE_FLAG == $past(wake_cond) && state_r == ST_RUN)
    else $error("wake flag not following condition");
  a_met_skip_sleep: assert property ( // R4
    run_exec && legal && precond_ok && !flag_r && wake_cond
    |=> state_r == ST_RUN && WAKE_FLAG && RESUME_VALID && !RESUME_AT_ZERO)
    else $error("met wake condition did not skip sleep");
  a_reset_wake_zero: assert property ( // R5
    state_r != ST_RUN && sup_s_r
    |=> RESUME_VALID && RESUME_AT_ZERO && state_r == ST_RUN && !CORE_HALT)
    else $error("supply reset wake not resuming at zero");
  a_deep_precond: assert property ( // R6
    run_exec && low == OP_DEEP_ALL_A && !(&KEY_IO_PINS_HIGH)
    |=> INTERNAL_RESET ##1 !INTERNAL_RESET)
    else $error("unmet key precondition not resetting");
  a_key0_precond: assert property ( // R7
    run_exec && low == OP_DEEP_KEY0 && KEY_IO_PINS_HIGH != KEY_IO_ONLY_ZERO
    |=> INTERNAL_RESET && state_r == ST_RUN)
    else $error("key zero precondition not enforced");
  a_sense_wake: assert property ( // R8 R9
    state_r == ST_DEEP && op_r[OP_SENSE_BIT] && sense_qual && !sup_s_r
    |=> state_r == ST_OSC_WAIT && !OSC_STOP)
    else $error("qualified sense pin did not wake");
  a_light_entry: assert property ( // R10
    run_exec && low == OP_LIGHT && !flag_r && !timer_zero
    |=> state_r == ST_LIGHT && CORE_HALT && !OSC_STOP)
    else $error("light sleep not entered");
  a_illegal_reset: assert property ( // R11
    run_exec && !legal |=> INTERNAL_RESET && !CORE_HALT)
    else $error("undefined operand not resetting");
  a_defer_hold: assert property ( // R12
    state_r == ST_DEFER && timer_busy && !sup_s_r
    |=> state_r == ST_DEFER && !OSC_STOP)
    else $error("deep sleep entered while timer busy");
  a_rearm_deep: assert property ( // R13
    state_r == ST_OSC_WAIT && ow.done && !wake_cond && !sup_s_r
    |=> state_r == ST_DEEP && OSC_STOP)
    else $error("did not return to deep sleep");
  a_light_osc_runs: assert property ( // R15
    state_r == ST_LIGHT |-> !OSC_STOP && CORE_HALT)
    else $error("oscillator stopped in light sleep");
  // The wait state must always have a live count behind it
  a_wait_running: assert property ( // R16
    state_r == ST_OSC_WAIT |-> ow.busy || ow.done)
    else $error("oscillator wait state without a running count");

  c_deep_wake: cover property (
    state_r == ST_OSC_WAIT && ow.done && wake_cond);
  c_light_wake: cover property (state_r == ST_LIGHT ##1 RESUME_VALID);
  c_deferred: cover property (state_r == ST_DEFER ##1 state_r == ST_DEEP);
  c_skip: cover property (run_exec && legal && precond_ok && wake_cond);

endmodule : standby_control

`default_nettype wire

// ### include/standby_pkg.sv
// Purpose: Shared constants and types for the standby entry/release control
// Assumes: 125 MHz system clock, AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses; every register is one aligned word

package standby_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_STATUS     = 8'h00;
  localparam logic [7:0]  ADDR_WAIT_LEN   = 8'h04;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Status register fields
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_FLAG_BIT   = 5;
  localparam int          STAT_ZERO_BIT   = 6;

  // ----------------------------------------------------------------------
  // Standby operand decode
  // ----------------------------------------------------------------------
  localparam logic [2:0]  OP_DEEP_ALL_A   = 3'h0;
  localparam logic [2:0]  OP_DEEP_ALL_B   = 3'h3;
  localparam logic [2:0]  OP_DEEP_KEY0    = 3'h6;
  localparam logic [2:0]  OP_LIGHT        = 3'h5;
  localparam int          OP_SENSE_BIT    = 3;
  localparam int          KEY_IO_W        = 8;
  localparam int          KEY_IN_W        = 4;
  localparam int          SENSE_W         = 3;
  localparam int          TIMER_W         = 10;
  localparam int          PCR_W           = 8;
  localparam logic [7:0]  KEY_IO_ONLY_ZERO = 8'h01;
  localparam int          PCR_S0_INPUT_BIT = 0;
  localparam int          PCR_S1_INPUT_BIT = 2;
  localparam int          PCR_S2_WAKE_BIT  = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned OSC_WAIT_NS     = 230000;
  // Least wait: round up to whole cycles
  localparam int unsigned OSC_WAIT_CYCLES =
    (OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAIT_W          = 16;

  // ----------------------------------------------------------------------
  // Sleep sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN      = 5'h01,
    ST_DEFER    = 5'h02,
    ST_DEEP     = 5'h04,
    ST_OSC_WAIT = 5'h08,
    ST_LIGHT    = 5'h10
  } sleep_state_e;

endpackage : standby_pkg

// ### include/osc_wait_if.sv
// Purpose: Carrier between the sleep sequencer and the oscillator wait timer
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse; done is a one-cycle pulse

`timescale 1ns/1ps
`default_nettype none

interface osc_wait_if;
  import standby_pkg::*;
  logic              start;
  logic [WAIT_W-1:0] len;
  logic              done;
  logic              busy;
  modport ctrl    (output start, output len, input done, input busy);
  modport counter (input start, input len, output done, output busy);
endinterface : osc_wait_if

`default_nettype wire

// ### logic/osc_wait_counter.sv
// Purpose: Oscillator stabilisation wait after a deep-sleep wake
// Assumes: len is stable while start is high
// Notes:   A length of zero is served as one cycle

`timescale 1ns/1ps
`default_nettype none

module osc_wait_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  osc_wait_if.counter     w
);
  import standby_pkg::*;

  logic [WAIT_W-1:0] cnt_r;
  logic [WAIT_W-1:0] cnt_nxt;
  logic              done_r;
  logic              done_nxt;

  // ----------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------
  // Load on start, count to zero, pulse done on the last step
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (w.start) begin
      cnt_nxt = (w.len == '0) ? WAIT_W'(1) : w.len; // R16
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - WAIT_W'(1);
      if (cnt_r == WAIT_W'(1)) begin
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign w.done = done_r;
  assign w.busy = (cnt_r != '0);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Helper: cycles since the last start and the length it asked for
  logic [WAIT_W:0]   el_r;
  logic [WAIT_W-1:0] len_q_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      el_r    <= '0;
      len_q_r <= '0;
    end else if (w.start) begin
      el_r    <= (WAIT_W+1)'(1);
      len_q_r <= (w.len == '0) ? WAIT_W'(1) : w.len;
    end else begin
      el_r    <= el_r + (WAIT_W+1)'(1);
    end
  end

  a_wait_exact_len: assert property ( // R16
    @(posedge clk) disable iff (!rst_n)
    w.done |-> el_r == {1'b0, len_q_r} + (WAIT_W+1)'(1))
    else $error("oscillator wait length differs from the loaded length");

endmodule : osc_wait_counter

`default_nettype wire

// ### sim/standby_seq_model.sv
// Purpose: Instruction sequencer model that issues standby instructions
// Assumes: Called from the bench; drives just after a rising edge
// Notes:   Operand flips outside the pulse so stale values never help
`timescale 1ns/1ps
`default_nettype none
module standby_seq_model (
  input  wire logic       clk,
  input  wire logic       resume,
  output var  logic       exec,
  output var  logic [3:0] operand,
  output var  logic       idle_slot
);
  // One-cycle instruction pulse, operand valid with it
  task automatic issue(input logic [3:0] op);
    @(posedge clk);
    exec    <= 1'b1;
    operand <= op;
    @(posedge clk);
    exec    <= 1'b0;
    operand <= ~op;
  endtask : issue
  // First slot after any resume is an idle instruction
  always_ff @(posedge clk) idle_slot <= resume;
  initial begin
    exec    = 1'b0;
    operand = 4'h0;
  end
endmodule : standby_seq_model
`default_nettype wire

// ### sim/tb_standby_entry_release_control.sv
// Purpose: Self-checking bench for the standby entry and release control
// Assumes: Outputs sampled at the rising edge, before that edge lands
// Notes:   Wait length cut to 4 cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb_standby_entry_release_control;
  import standby_pkg::*;
  logic CLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, FLAG_WR = 0, FLAG_WR_VAL = 0;
  logic TIMER_OUTPUT_ENABLE = 0, SUPPLY_MONITOR_RESET = 0, STBY_EXEC;
  logic [7:0] AWADDR = 0, ARADDR = 0, KEY_IO_PINS_HIGH = 8'hff;
  logic [7:0] PIN_CONTROL_REG = 0;
  logic [2:0] AWPROT = 0, ARPROT = 0, SENSE_PINS = 0;
  logic [3:0] WSTRB = 4'hf, KEY_INPUT_PINS = 0, STBY_OPERAND;
  logic [31:0] WDATA = 0, RDATA;
  logic [9:0] TIMER_COUNT = 0;
  logic [1:0] BRESP, RRESP;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WAKE_FLAG, CORE_HALT;
  logic OSC_STOP, INTERNAL_RESET, RESUME_VALID, RESUME_AT_ZERO;
  int   bad_count = 0, compares = 0;
  standby_control #(.OSC_WAIT_LEN(4)) uut (.*);
  standby_seq_model seq (.clk(CLK), .resume(RESUME_VALID),
    .exec(STBY_EXEC), .operand(STBY_OPERAND), .idle_slot());
  // 125 MHz clock
  always #4 CLK = ~CLK;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK);
      aw |= AWREADY & AWVALID;
      w |= WREADY & WVALID;
      AWVALID <= !aw;
      WVALID <= !w;
    end
    do @(posedge CLK); while (!BVALID);
    BREADY <= 1'b0;
    chk(32'(BRESP), 32'(RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    RREADY <= 1'b0;
    chk(RDATA, d);
    chk(32'(RRESP), 32'(r));
  endtask : rd
  task automatic setf(input logic v);
    @(posedge CLK);
    FLAG_WR <= 1'b1;
    FLAG_WR_VAL <= v;
    @(posedge CLK);
    FLAG_WR <= 1'b0;
  endtask : setf
  // Answer shows one edge after the instruction is taken
  task automatic stb(input logic [3:0] op);
    seq.issue(op);
    @(posedge CLK);
  endtask : stb
  task automatic wres(input logic z);
    repeat (200) begin
      @(posedge CLK);
      if (RESUME_VALID) break;
    end
    chk(RESUME_VALID, 1);
    chk(WAKE_FLAG, 1);
    chk(RESUME_AT_ZERO, z);
  endtask : wres
  // Undefined code or unmet key I/O state means internal reset
  function automatic logic bad_op(input logic [3:0] op, input logic [7:0] k);
    case (op[2:0])
      OP_DEEP_ALL_A, OP_DEEP_ALL_B: return k !== 8'hff;
      OP_DEEP_KEY0: return k !== KEY_IO_ONLY_ZERO;
      OP_LIGHT: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : bad_op
  initial begin
    void'($urandom(32'h406d2d4a));
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_WAIT_LEN, 32'h4);
    rd(ADDR_WAIT_LEN, 32'h4, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_SLVERR);
    TIMER_COUNT <= 10'($urandom_range(1023, 1));
    stb(4'h5);
    chk(CORE_HALT, 1);
    chk(OSC_STOP, 0);
    TIMER_COUNT <= 10'h0;
    wres(1'b0);
    TIMER_COUNT <= 10'h1;
    stb(4'hd);
    chk(RESUME_VALID, 1);
    chk(WAKE_FLAG, 0);
    TIMER_COUNT <= 10'h0;
    stb(4'h5);
    chk(RESUME_VALID, 1);
    chk(WAKE_FLAG, 1);
    setf(1'b0);
    SENSE_PINS <= 3'h4;
    PIN_CONTROL_REG <= 8'h08;
    repeat (3) @(posedge CLK);
    stb(4'h8);
    chk(RESUME_VALID, 1);
    SENSE_PINS <= 3'h0;
    // Every operand with the flag set: reset or stay awake
    for (int i = 0; i < 16; i++) begin
      setf(1'b1);
      TIMER_COUNT <= 10'h2;
      KEY_IO_PINS_HIGH <= ($urandom_range(2) == 0) ? 8'($urandom)
                        : ($urandom_range(1) ? 8'hff : 8'h01);
      stb(4'(i));
      chk(INTERNAL_RESET, bad_op(4'(i), KEY_IO_PINS_HIGH));
      chk(RESUME_VALID, !bad_op(4'(i), KEY_IO_PINS_HIGH));
    end
    setf(1'b0);
    KEY_IO_PINS_HIGH <= 8'hff;
    TIMER_OUTPUT_ENABLE <= 1'b1;
    stb(4'h0);
    chk(CORE_HALT, 1);
    TIMER_COUNT <= 10'h0;
    repeat (3) @(posedge CLK);
    chk(OSC_STOP, 0);
    TIMER_OUTPUT_ENABLE <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(OSC_STOP, 1);
    KEY_INPUT_PINS <= 4'h2;
    repeat (2) @(posedge CLK);
    KEY_INPUT_PINS <= 4'h0;
    repeat (20) @(posedge CLK);
    chk(OSC_STOP, 1);
    chk(WAKE_FLAG, 0);
    KEY_INPUT_PINS <= 4'h8;
    wres(1'b0);
    KEY_INPUT_PINS <= 4'h0;
    SENSE_PINS <= 3'h3;
    setf(1'b0);
    stb(4'hb);
    repeat (3) @(posedge CLK);
    chk(OSC_STOP, 1);
    PIN_CONTROL_REG <= 8'h01;
    wres(1'b0);
    TIMER_COUNT <= 10'h2;
    setf(1'b0);
    stb(4'h5);
    SUPPLY_MONITOR_RESET <= 1'b1;
    wres(1'b1);
    SUPPLY_MONITOR_RESET <= 1'b0;
    results();
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : tb_standby_entry_release_control
`default_nettype wire
